/* rtl/interrupt_priority_level_regs.sv */
// bank of four priority registers for the interrupt controller
// assumes an AXI4-Lite master on aclk and peripheral requests on aclk
//
// Notes on behaviour
// R01: breakpoint zero field bits 13..12, levels 1..3
// R02: step counter field bits 11..10, levels 1..3
// R03: reserved bits read zero, ignore writes
// R04: debug receive full field bits 5..4
// R05: debug transmit empty field bits 3..2
// R06: trace buffer field bits 1..0, levels 1..3
// R07: flash buffers empty bits 15..14, levels 0..2
// R08: flash command done bits 13..12, levels 0..2
// R09: flash error bits 11..10, levels 0..2
// R10: pll unlock bits 9..8, levels 0..2
// R11: low voltage bits 7..6, levels 0..2
// R12: external pin b bits 3..2
// R13: external pin a bits 1..0
// R14: ports d, e, f at 15..10
// R15: can message buffer bits 9..8
// R16: can wakeup bits 7..6
// R17: can error bits 5..4
// R18: can bus off bits 3..2
// R19: reset disables all; disabled never pending
// R20: first register at offset zero, 15..14 reserved
// R21: fields read back; level shown continuously
// R22: software configures source before nonzero code
`timescale 1ns/10ps
module interrupt_priority_level_regs #(
  parameter int unsigned ADDR_W = 8
) (
  // clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // write address channel
  input  wire logic [ADDR_W-1:0]           awaddr,
  input  wire logic                        awvalid,
  output logic                             awready,
  // write data channel
  input  wire logic [31:0]                 wdata,
  input  wire logic [3:0]                  wstrb,
  input  wire logic                        wvalid,
  output logic                             wready,
  // write response channel
  output logic [1:0]                       bresp,
  output logic                             bvalid,
  input  wire logic                        bready,
  // read address channel
  input  wire logic [ADDR_W-1:0]           araddr,
  input  wire logic                        arvalid,
  output logic                             arready,
  // read data channel
  output logic [31:0]                      rdata,
  output logic [1:0]                       rresp,
  output logic                             rvalid,
  input  wire logic                        rready,
  // peripheral requests in, gated requests and levels out
  input  wire logic [prio_pkg::NUM_SRC-1:0]   src_request,
  output logic [prio_pkg::NUM_SRC-1:0]        src_enable,
  output logic [2*prio_pkg::NUM_SRC-1:0]      src_level,
  output logic [prio_pkg::NUM_SRC-1:0]        src_pending
);

  localparam int unsigned NS = prio_pkg::NUM_SRC;

  // the decode needs address bits 3..2 plus room to tell unmapped
  if (ADDR_W < 5) begin : g_bad_addr_w
    $error("ADDR_W must be at least 5");
  end

  // whole state of the block
  typedef struct packed {
    logic [3:0][15:0]    regs;    // priority registers
    logic                aw_hold; // write address taken
    logic [ADDR_W-1:0]   awaddr;  // held write address
    logic                w_hold;  // write data taken
    logic [15:0]         wdata;   // held low half of write data
    logic [1:0]          wstrb;   // held strobes for the low half
    logic                awready; // ready for write address
    logic                wready;  // ready for write data
    logic                bvalid;  // write response waiting
    logic [1:0]          bresp;   // write response code
    logic                arready; // ready for read address
    logic                rvalid;  // read data waiting
    logic [31:0]         rdata;   // read data
    logic [1:0]          rresp;   // read response code
    logic [NS-1:0]       en;      // per-source enable
    logic [2*NS-1:0]     lvl;     // per-source level
    logic [NS-1:0]       pend;    // per-source gated request
  } state_t;

  state_t cur_r;                  // registered state
  state_t cur_nxt;                // next state

  // decoder results, combinational from the current registers
  logic [NS-1:0]       dec_en;
  logic [2*NS-1:0]     dec_lvl;
  logic [NS-1:0]       dec_pend;

  // address decode helpers
  logic [ADDR_W-1:0]   wr_addr;   // address of the write to perform
  logic [1:0]          wr_idx;    // register index of that write
  logic                wr_map;    // write lands on a register
  logic [1:0]          rd_idx;    // register index of a read
  logic                rd_map;    // read lands on a register
  logic [15:0]         wr_val;    // write data cut to writable bits

  // one decoder per source, field taken from its fixed position
  for (genvar i = 0; i < NS; i++) begin : g_src
    localparam logic [1:0] BASE_I = prio_pkg::SRC_DEBUG[i]
      ? prio_pkg::BASE_DEBUG : prio_pkg::BASE_PLAIN;
    logic [1:0] field;
    // field placement per source table
    assign field = cur_r.regs[prio_pkg::SRC_REG[i]]
                   [prio_pkg::SRC_LSB[i] +: 2]; // R01 R02 R04 R05 R06
    // the decoder output is registered once more below, so every level
    // leaves the block from a flop; the price is one cycle after a write
    level_decode #(
      .BASE    (BASE_I)
    ) u_dec ( // R07 R08 R09 R10 R11 R12 R13 R14 R15 R16 R17 R18
      .code    (field),
      .request (src_request[i]),
      .enable  (dec_en[i]),
      .level   (dec_lvl[2*i +: 2]),
      .pending (dec_pend[i])
    );
  end

  // next state: bus slave, register writes and output refresh
  always_comb begin
    cur_nxt = cur_r;
    wr_addr = '0;
    wr_idx  = 2'h0;
    wr_map  = 1'b0;
    rd_idx  = 2'h0;
    rd_map  = 1'b0;
    wr_val  = 16'h0000;

    // levels follow the registers every cycle
    cur_nxt.en   = dec_en;
    cur_nxt.lvl  = dec_lvl; // R21
    cur_nxt.pend = dec_pend; // R19

    // response taken by the master
    if (cur_r.bvalid && bready) begin
      cur_nxt.bvalid = 1'b0;
    end

    // capture write address and data, in either order
    if (awvalid && cur_r.awready) begin
      cur_nxt.aw_hold = 1'b1;
      cur_nxt.awaddr  = awaddr;
    end
    if (wvalid && cur_r.wready) begin
      cur_nxt.w_hold = 1'b1;
      cur_nxt.wdata  = wdata[15:0];
      cur_nxt.wstrb  = wstrb[1:0];
    end

    // both halves present: write and answer in one step
    if (cur_nxt.aw_hold && cur_nxt.w_hold && !cur_r.bvalid) begin
      wr_addr = cur_nxt.awaddr;
      wr_idx  = wr_addr[3:2];
      // upper address bits must be clear and the word aligned
      wr_map  = ((wr_addr >> 4) == '0) && (wr_addr[1:0] == 2'h0);
      // reserved bits never take a written one
      wr_val  = cur_nxt.wdata & prio_pkg::WR_MASK[wr_idx]; // R03 R20
      if (wr_map) begin
        if (cur_nxt.wstrb[0]) begin
          cur_nxt.regs[wr_idx][7:0] = wr_val[7:0]; // R21
        end
        if (cur_nxt.wstrb[1]) begin
          cur_nxt.regs[wr_idx][15:8] = wr_val[15:8]; // R21
        end
        cur_nxt.bresp = prio_pkg::RESP_OKAY;
      end else begin
        // unmapped address: nothing stored, error answer
        cur_nxt.bresp = prio_pkg::RESP_SLVERR;
      end
      cur_nxt.aw_hold = 1'b0;
      cur_nxt.w_hold  = 1'b0;
      cur_nxt.bvalid  = 1'b1;
    end

    // one write at a time: no new beats while a response waits
    cur_nxt.awready = !cur_nxt.aw_hold && !cur_nxt.bvalid;
    cur_nxt.wready  = !cur_nxt.w_hold && !cur_nxt.bvalid;

    // read data taken by the master
    if (cur_r.rvalid && rready) begin
      cur_nxt.rvalid = 1'b0;
    end

    // read: answer one cycle after the address is taken
    if (arvalid && cur_r.arready) begin
      rd_idx = araddr[3:2];
      rd_map = ((araddr >> 4) == '0) && (araddr[1:0] == 2'h0);
      cur_nxt.rvalid = 1'b1;
      if (rd_map) begin
        // masking keeps reserved bits at zero whatever is stored
        cur_nxt.rdata = {16'h0000, cur_r.regs[rd_idx]
                         & prio_pkg::WR_MASK[rd_idx]}; // R03 R21
        cur_nxt.rresp = prio_pkg::RESP_OKAY;
      end else begin
        cur_nxt.rdata = 32'h0000_0000;
        cur_nxt.rresp = prio_pkg::RESP_SLVERR;
      end
    end

    // one read at a time
    cur_nxt.arready = !cur_nxt.rvalid;
  end

  // state register; reset clears every field to the off code
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_r <= '0; // R19 R20
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // outputs straight from the state flops
  assign awready     = cur_r.awready;
  assign wready      = cur_r.wready;
  assign bvalid      = cur_r.bvalid;
  assign bresp       = cur_r.bresp;
  assign arready     = cur_r.arready;
  assign rvalid      = cur_r.rvalid;
  assign rdata       = cur_r.rdata;
  assign rresp       = cur_r.rresp;
  assign src_enable  = cur_r.en;
  assign src_level   = cur_r.lvl;
  assign src_pending = cur_r.pend;

  // checks on the design's own behaviour
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // write address and data arrive in the same cycle
  sequence s_wr_both;
    awvalid && awready && wvalid && wready;
  endsequence

  // a read address is taken
  sequence s_rd_take;
    arvalid && arready;
  endsequence

  // reserved bits never show on a read
  a_reserved_read_zero: assert property ( // R03
    rvalid |-> (rdata[31:16] == 16'h0000) &&
      ((rdata[15:0] & ~prio_pkg::WR_MASK[$past(araddr[3:2])]) == 16'h0
       || !$past(arvalid && arready))
  ) else $error("reserved bit read as one");

  // every register is at its reset value after reset
  a_reset_all_off: assert property ( // R19
    $rose(aresetn) |-> (cur_r.regs == {4{prio_pkg::REG_RESET}})
      ##1 (src_enable == '0)
  ) else $error("register not clear after reset");

  // a disabled source is never pending
  a_pending_gated: assert property ( // R19
    (src_pending & ~src_enable) == '0
  ) else $error("pending on disabled source");

  // stored values never hold a one in a reserved bit
  a_reserved_store: assert property ( // R03 R20
    (cur_r.regs[0] & ~prio_pkg::WR_MASK[0]) == 16'h0
    && (cur_r.regs[1] & ~prio_pkg::WR_MASK[1]) == 16'h0
    && (cur_r.regs[2] & ~prio_pkg::WR_MASK[2]) == 16'h0
    && (cur_r.regs[3] & ~prio_pkg::WR_MASK[3]) == 16'h0
  ) else $error("reserved bit stored");

  // per source: level range and level following the field
  for (genvar i = 0; i < NS; i++) begin : g_chk
    if (prio_pkg::SRC_DEBUG[i]) begin : g_dbg
      a_debug_range: assert property ( // R01
        src_enable[i] |-> src_level[2*i +: 2] != 2'h0
      ) else $error("debug source at level zero");
    end else begin : g_pln
      a_plain_range: assert property ( // R07
        src_enable[i] |-> src_level[2*i +: 2] != 2'h3
      ) else $error("plain source at level three");
    end
    a_level_follow: assert property ( // R21
      ##1 (src_level[2*i +: 2] == ($past(g_src[i].field) == 2'h0
        ? 2'h0 : 2'($past(g_src[i].field) - 2'h1
        + (prio_pkg::SRC_DEBUG[i] ? 2'h1 : 2'h0))))
    ) else $error("level does not follow field");
    // a disabled source always shows level zero
    a_level_zero_off: assert property ( // R19
      !src_enable[i] |-> src_level[2*i +: 2] == 2'h0
    ) else $error("level shown for disabled source");
  end

  // write answered one cycle after both halves are taken
  a_write_resp: assert property ( // R21
    s_wr_both |=> bvalid
  ) else $error("write response late");

  // read answered one cycle after the address is taken
  a_read_latency: assert property ( // R21
    s_rd_take |=> rvalid && !arready
  ) else $error("read data late");

  // read data stands until taken
  a_rdata_hold: assert property ( // R21
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp)
  ) else $error("read data dropped before taken");

  // write response stands until taken
  a_bresp_hold: assert property ( // R21
    bvalid && !bready |=> bvalid && $stable(bresp)
  ) else $error("write response dropped before taken");

  // no new address or data is taken while an answer waits
  a_busy_refuse: assert property ( // R21
    (!bvalid || (!awready && !wready)) && (!rvalid || !arready)
  ) else $error("bus taken while an answer waits");

  // a write response rises; the register update lands on that edge
  sequence s_wr_done;
    $rose(bvalid);
  endsequence

  // a refused write leaves every register as it was
  a_refused_keep: assert property ( // R03
    s_wr_done |-> bresp == prio_pkg::RESP_OKAY || $stable(cur_r.regs)
  ) else $error("refused write changed a register");

  // bus outputs come up idle out of reset
  a_reset_idle: assert property ( // R19
    $rose(aresetn) |-> !awready && !wready && !arready && !bvalid
      && !rvalid
  ) else $error("bus not idle after reset");

  // pending is the last request gated by the enable now shown
  a_pending_follow: assert property ( // R19
    src_pending == ($past(src_request) & src_enable)
  ) else $error("pending does not follow request");

endmodule

/* rtl/prio_pkg.sv */
// constants for the interrupt priority register bank
// assumes one 100 MHz clock and an AXI4-Lite register bus
package prio_pkg;

  // register indexes; byte address is four times the index
  localparam int unsigned NUM_REGS = 4;
  localparam logic [1:0] IDX_DEBUG_BREAK_STEP = 2'h0;
  localparam logic [1:0] IDX_DEBUG_TRANSFER   = 2'h1;
  localparam logic [1:0] IDX_FLASH_CLOCK_PINS = 2'h2;
  localparam logic [1:0] IDX_PORTS_CAN        = 2'h3;
  localparam int unsigned BYTES_PER_REG = 4;

  // value of every register after reset
  localparam logic [15:0] REG_RESET = 16'h0000;

  // writable bits per register, highest index first
  localparam logic [3:0][15:0] WR_MASK = {
    16'hfffc,  // ports and can, bits 1..0 reserved
    16'hffcf,  // flash, clock, pins, bits 5..4 reserved
    16'h003f,  // debug transfer, bits 15..6 reserved
    16'h3c00   // debug break and step, 15..14 and 9..0 reserved
  };

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // field codes and level offsets
  localparam logic [1:0] CODE_OFF   = 2'h0;
  localparam logic [1:0] BASE_DEBUG = 2'h1;  // codes map to 1..3
  localparam logic [1:0] BASE_PLAIN = 2'h0;  // codes map to 0..2
  localparam logic [1:0] FIELD_W    = 2'h2;

  // source table: register, low bit, debug range
  localparam int unsigned NUM_SRC = 19;
  localparam int unsigned SRC_REG [NUM_SRC] = '{
    0, 0, 1, 1, 1, 2, 2, 2, 2, 2, 2, 2, 3, 3, 3, 3, 3, 3, 3};
  localparam int unsigned SRC_LSB [NUM_SRC] = '{
    12, 10, 4, 2, 0, 14, 12, 10, 8, 6, 2, 0,
    14, 12, 10, 8, 6, 4, 2};
  localparam bit SRC_DEBUG [NUM_SRC] = '{
    1, 1, 1, 1, 1, 0, 0, 0, 0, 0, 0, 0,
    0, 0, 0, 0, 0, 0, 0};

endpackage

/* rtl/level_decode.sv */
// one priority field turned into enable, level and gated request
// assumes the field and the request are on the bus clock
`timescale 1ns/10ps
module level_decode #(
  parameter logic [1:0] BASE = prio_pkg::BASE_PLAIN
) (
  // field from the register bank
  input  wire logic [1:0] code,
  // raw request from the peripheral
  input  wire logic       request,
  // decoded result
  output logic            enable,
  output logic [1:0]      level,
  output logic            pending
);

  // a zero code disables the source
  assign enable = (code != prio_pkg::CODE_OFF); // R19

  // nonzero code minus one plus the range base; zero when disabled
  assign level = enable ? 2'(code - 2'h1 + BASE) : 2'h0; // R21

  // a disabled source is never passed on as pending
  assign pending = request & enable; // R19

endmodule

/* testbench/request_source.sv */
// model of the peripheral request sources in front of the priority bank
// assumes requests are plain levels on the bus clock
`timescale 1ns/10ps
module request_source (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // raw requests toward the bank
  output logic [18:0]      src_request
);
  integer seed = 32'h28361706;  // fixed seed, repeatable runs

  initial src_request = 19'h00000;
  // new levels every cycle so a stale or ungated pending shows up
  always @(posedge aclk) begin
    if (!aresetn) begin
      src_request <= 19'h00000;
    end else begin
      src_request <= 19'($random(seed));
    end
  end
endmodule

/* testbench/tb_interrupt_priority_level_regs.sv */
// self-checking bench for the interrupt priority register bank
// assumes the design package is compiled first; one 100 MHz clock
`timescale 1ns/10ps
module tb_interrupt_priority_level_regs;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  logic [18:0] src_request, src_enable, src_pending, req_q;
  logic [37:0] src_level;
  logic [15:0] mreg [4];  // model of the four registers
  integer      mismatches = 0, total_checks = 0, r, lag = 0;
  integer      seed = 32'h28361706;  // stimulus seed

  interrupt_priority_level_regs dut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .src_request(src_request), .src_enable(src_enable),
    .src_level(src_level), .src_pending(src_pending));
  request_source partner (.aclk(aclk), .aresetn(aresetn),
    .src_request(src_request));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // request as seen by the bank at the last edge
  always @(posedge aclk) req_q <= src_request;

  task check(input logic [63:0] seen, input logic [63:0] exp,
             input string what);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask

  // true for an aligned address inside the four registers
  function automatic bit mapped(input logic [7:0] a);
    return a[7:4] == 4'h0 && a[1:0] == 2'h0;
  endfunction

  // one write; address and data released as each is taken
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [15:0] m;
    int          n;
    n = 0;
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= s;
    wvalid <= 1'b1; bready <= (lag == 0);
    // bready may come late, then stands until the response is taken
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      n++;
      if (!bready && n >= lag) bready <= 1'b1;
    end while (!(bvalid && bready));
    rsp = bresp;
    bready <= 1'b0;
    // lane 0 holds bits 7..0, lane 1 bits 15..8; reserved bits dropped
    m = prio_pkg::WR_MASK[a[3:2]] & {{8{s[1]}}, {8{s[0]}}};
    if (mapped(a)) mreg[a[3:2]] = (mreg[a[3:2]] & ~m) | (d[15:0] & m);
    check(rsp, mapped(a) ? prio_pkg::RESP_OKAY : prio_pkg::RESP_SLVERR,
          "write response");
  endtask

  // one read compared with the model
  task rd_chk(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= (lag == 0);
    // rready may come late, then stands until the data is taken
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      n++;
      if (!rready && n >= lag) rready <= 1'b1;
    end while (!(rvalid && rready));
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
    check(rd, mapped(a) ? {16'h0000, mreg[a[3:2]]} : 32'h0,
          "read data");
    check(rsp, mapped(a) ? prio_pkg::RESP_OKAY : prio_pkg::RESP_SLVERR,
          "read response");
  endtask

  // decoded outputs against the model over several settled cycles
  task out_chk();
    logic [1:0]  c;
    logic [18:0] en;
    logic [37:0] lv;
    for (int i = 0; i < 19; i++) begin
      c = 2'(mreg[prio_pkg::SRC_REG[i]] >> prio_pkg::SRC_LSB[i]);
      en[i] = c != 2'h0;
      // debug sources map codes to 1..3, the rest to 0..2
      lv[2*i +: 2] = (c == 2'h0) ? 2'h0 :
                     prio_pkg::SRC_DEBUG[i] ? c : c - 2'h1;
    end
    repeat (3) @(posedge aclk);
    repeat (4) begin
      @(negedge aclk);
      check(src_enable, en, "enables");
      check(src_level, lv, "levels");
      check(src_pending, req_q & en, "pending");
    end
  endtask

  task finish_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // a hang counts as a mismatch and still ends in the verdict
  initial begin
    #500000;
    mismatches++;
    finish_test();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    mreg = '{default: 16'h0000};
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    out_chk();
    for (int i = 0; i < 4; i++) rd_chk(8'(4 * i));
    // every code into every field, all four registers; the model's
    // sources count as set up before any nonzero code goes in
    for (int c = 0; c < 4; c++) begin
      for (int i = 0; i < 4; i++) wr(8'(4 * i), {16'h0, {8{2'(c)}}}, 4'hf);
      for (int i = 0; i < 4; i++) rd_chk(8'(4 * i));
      out_chk();
    end
    // random data, lanes and registers
    repeat (30) begin
      r = $random(seed);
      lag = r[12:11];  // answers taken 0 to 3 cycles late
      wr({4'h0, r[1:0], 2'h0}, $random(seed), r[7:4]);
      rd_chk({4'h0, r[9:8], 2'h0});
      out_chk();
    end
    // unmapped and misaligned places refuse and store nothing
    wr(8'h10, 32'hffffffff, 4'hf);
    wr(8'h06, 32'hffffffff, 4'hf);
    rd_chk(8'h10);
    rd_chk(8'h05);
    // reset in mid-run clears every field
    for (int i = 0; i < 4; i++) wr(8'(4 * i), 32'hffffffff, 4'h3);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    mreg = '{default: 16'h0000};
    out_chk();
    for (int i = 0; i < 4; i++) rd_chk(8'(4 * i));
    finish_test();
  end
endmodule
